// [ahlc_pkg.sv]
package ahlc_pkg;
  // array geometry
  localparam int DW    = 32;
  localparam int AW    = 12;
  localparam int DEPTH = 4096;
  localparam int PGW   = 4;
  localparam int NMASK = 7;
  localparam int APBAW = 8;
  // apb byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_INSTR  = 8'h04;
  localparam logic [7:0] OFF_DEVSEL = 8'h08;
  localparam logic [7:0] OFF_ADDR   = 8'h0c;
  localparam logic [7:0] OFF_CMP    = 8'h10;
  localparam logic [7:0] OFF_DATA   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK1  = 8'h20;
  localparam logic [7:0] OFF_MASK7  = 8'h38;
  // field positions
  localparam int CFG_SW_BIT    = 0;
  localparam int CFG_PAGE_LSB  = 4;
  localparam int INS_WRITE_BIT = 12;
  localparam int INS_VB_BIT    = 13;
  localparam int ST_MATCH_BIT  = 0;
  localparam int ST_FULL_BIT   = 1;
  localparam int ST_VB_BIT     = 2;
  localparam int ST_ADDR_LSB   = 4;
  localparam int ST_PAGE_LSB   = 16;
  localparam int CAT_LSB       = 8;
  localparam int CAT_MSB       = 11;
  localparam int CMP_SRC_BIT   = 3;
  localparam int CMP_LOAD_BIT  = 4;
  // reset values
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] DEVSEL_RST = 32'h0000_0001;
  // control state categories on addr_ctrl_bus[11:8]
  typedef enum logic [3:0] {
    CAT_NOP   = 4'h0,
    CAT_MEM   = 4'h1,
    CAT_NFA   = 4'h2,
    CAT_CMP   = 4'h3,
    CAT_VALID = 4'h4,
    CAT_ADDR  = 4'h5,
    CAT_REG   = 4'h6,
    CAT_MOVE  = 4'h7,
    CAT_INIT  = 4'h8,
    CAT_VP    = 4'h9
  } ahlc_cat_e;
  // address register step on addr_ctrl_bus[1:0]
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  // register index on addr_ctrl_bus[3:0] for CAT_REG
  localparam logic [3:0] RIX_CMP   = 4'h0;
  localparam logic [3:0] RIX_ADDR  = 4'h1;
  localparam logic [3:0] RIX_MASK1 = 4'h2;
endpackage : ahlc_pkg

// [ahlc_cam.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - array of 4K words, 32 bits each, 32-bit data path.
// - validity line travels with data on array writes and reads, except move writes, which always set valid.
// - control state on addr_ctrl_bus selects the operation category.
// - compare comparand or data bus; optionally load data into comparand.
// - match drives page_out:active_addr_out qualified by match flag.
// - seven masks; mask bits high force a match on that bit.
// - configuration register holds mode and page value.
// - status register mirrors last read, write or compare results.
// - hardware or software control mode; software uses instruction register.
// - device select register gates software instructions for this device.
// - addr_valid_n low makes addr_ctrl_bus a direct array address.
// - indirect access uses the previously loaded address register.
// - some read/write states step the address register up or down.
// - next-free write lands in lowest-numbered empty location.
// - next-free write hits only the first non-full device in cascade.
// - two chains, match/priority and full/next-free, any depth.
// - pin inputs are captured on the chip-enable falling edge.
// - in hardware mode, compare results reach the pins only after chip enable rises.
// - match from higher device overrides this device's own match.
// - full flag asserts only when every location is valid.
module ahlc_cam
  import ahlc_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic [APBAW-1:0] paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [DW-1:0]    pwdata,
  output logic      [DW-1:0]    prdata,
  output logic                  pready,
  output logic                  pslverr,
  // strobe and control pins
  input  wire logic             chip_enable_n,
  input  wire logic             chip_select_n,
  input  wire logic             write_n,
  input  wire logic             addr_valid_n,
  input  wire logic [AW-1:0]    addr_ctrl_bus,
  // data and validity pins
  input  wire logic [DW-1:0]    data_bus_in,
  output logic      [DW-1:0]    data_bus_out,
  output logic                  data_bus_oe,
  input  wire logic             validity_line_in,
  output logic                  validity_line_out,
  output logic                  validity_line_oe,
  // cascade chains
  input  wire logic             cascade_match_in_n,
  input  wire logic             cascade_full_in_n,
  output logic                  cam_match_flag_n,
  output logic                  array_full_flag_n,
  // associated data pointer
  output logic      [PGW-1:0]   page_out,
  output logic      [AW-1:0]    active_addr_out
);
  localparam int SW = AW + DW + 7;

  // lowest set bit wins; returns {found, index}
  function automatic logic [AW:0] first_set(input logic [DEPTH-1:0] v);
    logic [AW:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (v[i]) r = {1'b1, AW'(i)};
    end
    return r;
  endfunction : first_set

  logic [DW-1:0]  mem_q [DEPTH];
  logic [DEPTH-1:0] valid_q;
  logic [DW-1:0]  config_q, devsel_q, data_q, result_q, cmp_q;
  logic [DW-1:0]  mask_q [NMASK];
  logic [AW-1:0]  addr_q, pend_addr_q;
  logic           pend_q, pend_hit_q, own_match_q, result_vb_n_q;
  logic [SW-1:0]  pin_s1_q, pin_s2_q;
  logic           ce_s3_q;

  // two-flop capture of all pins; logic reads s2 plus a third chip-enable flop for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      ce_s3_q  <= 1'b1;
    end else begin
      pin_s1_q <= {chip_enable_n, chip_select_n, write_n, addr_valid_n, validity_line_in,
                   cascade_match_in_n, cascade_full_in_n, addr_ctrl_bus, data_bus_in};
      pin_s2_q <= pin_s1_q;
      ce_s3_q  <= pin_s2_q[SW-1];
    end
  end

  // unpack synchronised pins
  wire          ce_n_s = pin_s2_q[SW-1];
  wire          cs_n_s = pin_s2_q[SW-2];
  wire          w_n_s  = pin_s2_q[SW-3];
  wire          av_n_s = pin_s2_q[SW-4];
  wire          vb_n_s = pin_s2_q[SW-5];
  wire          mi_n_s = pin_s2_q[SW-6];
  wire          fi_n_s = pin_s2_q[SW-7];
  wire [AW-1:0] ac_s   = pin_s2_q[AW+DW-1:DW];
  wire [DW-1:0] dq_s   = pin_s2_q[DW-1:0];
  wire          ce_fall = ce_s3_q & ~ce_n_s;
  wire          ce_rise = ~ce_s3_q & ce_n_s;

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready & pwrite;
  wire is_mask   = (paddr >= OFF_MASK1) && (paddr <= OFF_MASK7) && (paddr[1:0] == 2'b00);
  wire [2:0] apb_mix = 3'((paddr - OFF_MASK1) >> 2);
  wire addr_hit  = is_mask || paddr == OFF_CONFIG || paddr == OFF_INSTR ||
                   paddr == OFF_DEVSEL || paddr == OFF_ADDR || paddr == OFF_CMP ||
                   paddr == OFF_DATA || paddr == OFF_STATUS;

  // operation source: pins in hardware mode, instruction register in software mode
  wire sw_mode = config_q[CFG_SW_BIT];
  wire hw_go   = ce_fall & ~cs_n_s & ~sw_mode;
  wire sw_go   = apb_wr & (paddr == OFF_INSTR) & sw_mode & devsel_q[0];
  wire op_go   = hw_go | sw_go;
  wire [AW-1:0] op_ctl    = sw_go ? pwdata[AW-1:0] : ac_s;
  wire          op_write  = sw_go ? pwdata[INS_WRITE_BIT] : ~w_n_s;
  wire          op_vb_n   = sw_go ? pwdata[INS_VB_BIT] : vb_n_s;
  wire [DW-1:0] op_data   = sw_go ? data_q : dq_s;
  wire          op_direct = hw_go & ~av_n_s;
  wire ahlc_cat_e op_cat  = op_direct ? CAT_MEM : ahlc_cat_e'(op_ctl[CAT_MSB:CAT_LSB]);
  wire [1:0]    op_step   = op_direct ? 2'b00 : op_ctl[1:0];
  wire [AW-1:0] mem_addr  = op_direct ? op_ctl : addr_q;
  wire [3:0]    reg_ix    = op_ctl[3:0];
  wire [2:0]    msk_sel   = op_ctl[2:0];

  // compare key and mask selection
  wire [DW-1:0] key  = op_ctl[CMP_SRC_BIT] ? cmp_q : op_data;
  wire [DW-1:0] mask = (msk_sel == 3'd0) ? '0 : mask_q[msk_sel - 3'd1];

  // fully parallel match over the whole array
  logic [DEPTH-1:0] hit_vec;
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      hit_vec[i] = valid_q[i] & (((mem_q[i] ^ key) & ~mask) == '0);
    end
  end

  wire [AW:0]   hit_enc  = first_set(hit_vec);
  wire [AW:0]   free_enc = first_set(~valid_q);
  wire          own_full = &valid_q;
  wire          nfa_ok   = free_enc[AW] & ~fi_n_s;
  wire [AW-1:0] free_idx = free_enc[AW-1:0];

  // array write path
  wire is_cmp   = op_go && op_cat == CAT_CMP;
  wire is_nfa   = op_go && op_cat == CAT_NFA;
  wire mem_wr   = op_go && ((op_cat == CAT_MEM && op_write) || op_cat == CAT_MOVE ||
                            (op_cat == CAT_NFA && nfa_ok));
  wire mem_rd   = op_go && op_cat == CAT_MEM && !op_write;
  wire reg_rd   = op_go && op_cat == CAT_REG && !op_write;
  wire reg_wr   = op_go && op_cat == CAT_REG && op_write;
  wire [AW-1:0] wr_addr = (op_cat == CAT_NFA) ? free_idx : mem_addr;
  wire [DW-1:0] wr_data = (op_cat == CAT_MOVE) ? cmp_q : op_data;
  wire          wr_vb_n = (op_cat == CAT_MOVE) ? 1'b0 : op_vb_n;
  wire [DW-1:0] reg_val = (reg_ix == RIX_CMP) ? cmp_q :
                          (reg_ix == RIX_ADDR) ? {{(DW-AW){1'b0}}, addr_q} :
                          (reg_ix >= RIX_MASK1 && reg_ix < RIX_MASK1 + 4'(NMASK)) ?
                          mask_q[3'(reg_ix - RIX_MASK1)] : '0;
  wire          rd_vb_n = ~valid_q[mem_addr];

  // array storage, no reset on the data words
  always_ff @(posedge pclk) begin
    if (mem_wr) mem_q[wr_addr] <= wr_data;
  end

  // validity bits; reset and init leave every location empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) valid_q <= '0;
    else if (op_go && op_cat == CAT_INIT) valid_q <= '0;
    else if (mem_wr) valid_q[wr_addr] <= ~wr_vb_n;
    else if (op_go && op_cat == CAT_VALID) valid_q[addr_q] <= ~op_vb_n;
  end

  // address register: pins take priority over apb in the same cycle
  wire step_op = op_go && !op_direct && (op_cat == CAT_MEM);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) addr_q <= '0;
    else if (op_go && op_cat == CAT_INIT) addr_q <= '0;
    else if (op_go && op_cat == CAT_ADDR) addr_q <= op_data[AW-1:0];
    else if (reg_wr && reg_ix == RIX_ADDR) addr_q <= op_data[AW-1:0];
    else if (step_op && op_step == STEP_INC) addr_q <= addr_q + 12'h001;
    else if (step_op && op_step == STEP_DEC) addr_q <= addr_q - 12'h001;
    else if (apb_wr && paddr == OFF_ADDR) addr_q <= pwdata[AW-1:0];
  end

  // comparand, optionally loaded from the data bus during a compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmp_q <= '0;
    else if (is_cmp && op_ctl[CMP_LOAD_BIT]) cmp_q <= op_data;
    else if (reg_wr && reg_ix == RIX_CMP) cmp_q <= op_data;
    else if (apb_wr && paddr == OFF_CMP) cmp_q <= pwdata;
  end

  // mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NMASK; k++) mask_q[k] <= '0;
    end else if (reg_wr && reg_ix >= RIX_MASK1 && reg_ix < RIX_MASK1 + 4'(NMASK)) begin
      mask_q[3'(reg_ix - RIX_MASK1)] <= op_data;
    end else if (apb_wr && is_mask) begin
      mask_q[apb_mix] <= pwdata;
    end
  end

  // configuration, device select and software operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= CONFIG_RST;
      devsel_q <= DEVSEL_RST;
      data_q   <= '0;
    end else if (apb_wr) begin
      if (paddr == OFF_CONFIG) config_q <= pwdata;
      if (paddr == OFF_DEVSEL) devsel_q <= pwdata;
      if (paddr == OFF_DATA) data_q <= pwdata;
    end
  end

  // read results and the pin data drivers; drivers drop when chip enable rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q          <= '0;
      result_vb_n_q     <= 1'b1;
      data_bus_out      <= '0;
      data_bus_oe       <= 1'b0;
      validity_line_out <= 1'b1;
      validity_line_oe  <= 1'b0;
    end else if (mem_rd || reg_rd) begin
      result_q          <= mem_rd ? mem_q[mem_addr] : reg_val;
      result_vb_n_q     <= mem_rd ? rd_vb_n : 1'b1;
      data_bus_out      <= mem_rd ? mem_q[mem_addr] : reg_val;
      data_bus_oe       <= hw_go;
      validity_line_out <= mem_rd ? rd_vb_n : 1'b1;
      validity_line_oe  <= hw_go & mem_rd;
    end else if (ce_rise) begin
      data_bus_oe      <= 1'b0;
      validity_line_oe <= 1'b0;
    end
  end

  // compare result waits in pend until chip enable rises in hardware mode
  // so the external ram can still use the old pointer meanwhile
  wire apply_now = (is_cmp && sw_go) || (pend_q && ce_rise);
  wire new_hit   = (is_cmp && sw_go) ? hit_enc[AW] : pend_hit_q;
  wire [AW-1:0] new_addr = (is_cmp && sw_go) ? hit_enc[AW-1:0] : pend_addr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q      <= 1'b0;
      pend_hit_q  <= 1'b0;
      pend_addr_q <= '0;
    end else if (is_cmp && hw_go) begin
      pend_q      <= 1'b1;
      pend_hit_q  <= hit_enc[AW];
      pend_addr_q <= hit_enc[AW-1:0];
    end else if (ce_rise) begin
      pend_q <= 1'b0;
    end
  end

  // pointer outputs and match chain; higher device match suppresses ours
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_match_q      <= 1'b0;
      cam_match_flag_n <= 1'b1;
      active_addr_out  <= '0;
      page_out         <= '0;
    end else if (apply_now) begin
      own_match_q      <= new_hit;
      cam_match_flag_n <= ~(new_hit | ~mi_n_s);
      if (new_hit && mi_n_s) begin
        active_addr_out <= new_addr;
        page_out        <= config_q[CFG_PAGE_LSB +: PGW];
      end
    end else if (mem_wr || mem_rd) begin
      active_addr_out <= wr_addr;
      page_out        <= config_q[CFG_PAGE_LSB +: PGW];
    end
  end

  // full chain: asserts only when this array and all above are full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) array_full_flag_n <= 1'b1;
    else array_full_flag_n <= ~(own_full & ~fi_n_s);
  end

  // status mirrors the pointer and full pins; its match bit is this device's own match
  wire [DW-1:0] status = {{(DW-ST_PAGE_LSB-PGW){1'b0}}, page_out,
                          active_addr_out, 1'b0, result_vb_n_q,
                          ~array_full_flag_n, own_match_q};
  wire [DW-1:0] rd_mux = is_mask ? mask_q[apb_mix] :
                         (paddr == OFF_CONFIG) ? config_q :
                         (paddr == OFF_DEVSEL) ? devsel_q :
                         (paddr == OFF_ADDR)   ? {{(DW-AW){1'b0}}, addr_q} :
                         (paddr == OFF_CMP)    ? cmp_q :
                         (paddr == OFF_DATA)   ? result_q :
                         (paddr == OFF_STATUS) ? status : '0;

  // apb answer: read data and error taken in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
      if (apb_setup) prdata <= (pwrite || !addr_hit) ? '0 : rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_flag_all: assert property (!array_full_flag_n |-> $past(own_full))
    else $error("full flag with an empty location");
  a_cmp_pins_hold: assert property ((is_cmp && hw_go) |=>
    $stable(cam_match_flag_n) && $stable(page_out))
    else $error("compare result changed before chip enable rose");
  a_cascade_prio: assert property ((is_cmp && sw_go && !mi_n_s) |=>
    !cam_match_flag_n && $stable(active_addr_out))
    else $error("higher device match not honoured");
  a_nfa_lowest: assert property ((is_nfa && nfa_ok) |=>
    valid_q[$past(free_idx)] && $past(free_idx) == active_addr_out)
    else $error("next free write missed lowest empty slot");
  a_nfa_chain: assert property ((is_nfa && fi_n_s) |=> valid_q == $past(valid_q))
    else $error("next free write taken while higher device not full");
  a_addr_inc: assert property ((step_op && op_step == STEP_INC) |=>
    addr_q == 12'($past(addr_q) + 12'h001))
    else $error("address register did not increment");
  a_direct_write: assert property ((op_go && op_direct && op_write) |=>
    mem_q[$past(mem_addr)] == $past(op_data))
    else $error("direct write not stored at bus address");
  a_indirect_wr: assert property ((step_op && op_write) |=>
    mem_q[$past(addr_q)] == $past(op_data))
    else $error("indirect write not stored at address register");
  a_sw_pins_off: assert property ((sw_mode && ce_fall && !sw_go && !apb_wr) |=>
    valid_q == $past(valid_q))
    else $error("pin strobe acted in software mode");
endmodule : ahlc_cam

// [ahlc_pin_host.sv]
`timescale 1ns/1ps
module ahlc_pin_host
  import ahlc_pkg::*;
(
  // clock
  input  wire logic          pclk,
  // strobe and control
  output logic               chip_enable_n,
  output logic               chip_select_n,
  output logic               write_n,
  output logic               addr_valid_n,
  output logic [AW-1:0]      addr_ctrl_bus,
  // resolved data and validity wires
  output logic [DW-1:0]      data_bus_in,
  input  wire logic [DW-1:0] data_bus_out,
  input  wire logic          data_bus_oe,
  output logic               validity_line_in,
  input  wire logic          validity_line_out,
  input  wire logic          validity_line_oe,
  // cascade neighbours
  output logic               cascade_match_in_n,
  output logic               cascade_full_in_n,
  // pointer seen by the associated ram
  input  wire logic          cam_match_flag_n,
  input  wire logic [AW-1:0] active_addr_out
);
  logic [DW-1:0] drv_q;
  logic          vb_q;
  logic          drv_oe_q;
  logic [AW-1:0] mid_aa_q;
  logic          mid_mf_q;

  // released wires show the inverse of our last value, so a stale copy never passes
  assign data_bus_in      = data_bus_oe ? data_bus_out : (drv_oe_q ? drv_q : ~drv_q);
  assign validity_line_in = validity_line_oe ? validity_line_out : (drv_oe_q ? vb_q : ~vb_q);

  // idle pins; top of the chain, so full-in sits low
  initial begin
    chip_enable_n      = 1'b1;
    chip_select_n      = 1'b0;
    write_n            = 1'b1;
    addr_valid_n       = 1'b1;
    addr_ctrl_bus      = '0;
    drv_q              = '0;
    vb_q               = 1'b1;
    drv_oe_q           = 1'b0;
    cascade_match_in_n = 1'b1;
    cascade_full_in_n  = 1'b0;
  end

  // one strobe: inputs settle 4 pclk before the fall and hold while low
  task automatic cycle(input logic wr_n, input logic av_n, input logic [AW-1:0] ac,
                       input logic [DW-1:0] d, input logic vb,
                       output logic [DW-1:0] rd, output logic rvb);
    @(posedge pclk);
    write_n       <= wr_n;
    addr_valid_n  <= av_n;
    addr_ctrl_bus <= ac;
    drv_q         <= d;
    vb_q          <= vb;
    drv_oe_q      <= ~wr_n;  // reads leave the wires to the device
    repeat (4) @(posedge pclk);
    chip_enable_n <= 1'b0;
    repeat (5) @(posedge pclk);
    rd       = data_bus_in;
    rvb      = validity_line_in;
    mid_aa_q = active_addr_out;
    mid_mf_q = cam_match_flag_n;
    chip_enable_n <= 1'b1;
    repeat (6) @(posedge pclk);
    drv_oe_q <= 1'b0;
  endtask : cycle
endmodule : ahlc_pin_host

// [atm_header_lookup_cam_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module atm_header_lookup_cam_tb
  import ahlc_pkg::*;
;
  localparam logic [DW-1:0] PAT = 32'h1234_5678;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [APBAW-1:0] paddr;
  logic [DW-1:0]    pwdata, prdata, data_bus_in, data_bus_out, rd, rdata_r;
  logic             chip_enable_n, chip_select_n, write_n, addr_valid_n, data_bus_oe;
  logic [AW-1:0]    addr_ctrl_bus, active_addr_out;
  logic             validity_line_in, validity_line_out, validity_line_oe, rvb, rerr_r;
  logic             cascade_match_in_n, cascade_full_in_n, cam_match_flag_n, array_full_flag_n;
  logic [PGW-1:0]   page_out;
  int               fail_count, checks_done;

  ahlc_cam i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_enable_n(chip_enable_n), .chip_select_n(chip_select_n),
    .write_n(write_n), .addr_valid_n(addr_valid_n), .addr_ctrl_bus(addr_ctrl_bus),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .validity_line_in(validity_line_in), .validity_line_out(validity_line_out),
    .validity_line_oe(validity_line_oe), .cascade_match_in_n(cascade_match_in_n),
    .cascade_full_in_n(cascade_full_in_n), .cam_match_flag_n(cam_match_flag_n),
    .array_full_flag_n(array_full_flag_n), .page_out(page_out),
    .active_addr_out(active_addr_out));

  ahlc_pin_host i_host (.pclk(pclk), .chip_enable_n(chip_enable_n),
    .chip_select_n(chip_select_n), .write_n(write_n), .addr_valid_n(addr_valid_n),
    .addr_ctrl_bus(addr_ctrl_bus), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .validity_line_in(validity_line_in),
    .validity_line_out(validity_line_out), .validity_line_oe(validity_line_oe),
    .cascade_match_in_n(cascade_match_in_n), .cascade_full_in_n(cascade_full_in_n),
    .cam_match_flag_n(cam_match_flag_n), .active_addr_out(active_addr_out));

  // 200 mhz clock
  always #2.5 pclk = ~pclk;

  // apb transfer; waits for pready, the watchdog alone ends a dead wait
  task automatic apb(input logic wr, input logic [APBAW-1:0] a, input logic [DW-1:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata_r = prdata;
    rerr_r  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one pin-side operation through the host model
  task automatic hw(input logic wr_n, input logic av_n, input logic [AW-1:0] ac,
                    input logic [DW-1:0] d, input logic vb);
    i_host.cycle(wr_n, av_n, ac, d, vb, rd, rvb);
  endtask : hw

  // verdict and the single exit point
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // watchdog sized above the full-array fill of about 66k cycles
  initial begin
    repeat (95000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; fail_count = 0; checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(cam_match_flag_n, 1'b1)
    `CHK(array_full_flag_n, 1'b1)
    apb(1'b0, OFF_CONFIG, '0);
    `CHK(rdata_r, CONFIG_RST)
    apb(1'b0, OFF_DEVSEL, '0);
    `CHK(rdata_r, DEVSEL_RST)
    apb(1'b0, 8'h40, '0);
    `CHK({rerr_r, rdata_r}, {1'b1, 32'h0000_0000})
    apb(1'b1, OFF_CONFIG, 32'h0000_0030); // page 3, hardware mode
    // direct writes at 9 and 5, then direct reads
    hw(1'b0, 1'b0, 12'd9, PAT, 1'b0);
    hw(1'b0, 1'b0, 12'd5, PAT, 1'b0);
    hw(1'b1, 1'b0, 12'd5, '0, 1'b1);
    `CHK({rvb, rd}, {1'b0, PAT})
    hw(1'b1, 1'b0, 12'd6, '0, 1'b1);
    `CHK(rvb, 1'b1)
    // compare from the data bus; pointer holds until the strobe rises
    hw(1'b0, 1'b1, {CAT_CMP, 8'h00}, PAT, 1'b0);
    `CHK({i_host.mid_mf_q, i_host.mid_aa_q}, {1'b1, 12'd6})
    `CHK({cam_match_flag_n, page_out, active_addr_out}, {1'b0, 4'h3, 12'd5})
    apb(1'b0, OFF_STATUS, '0);
    `CHK({rdata_r[ST_PAGE_LSB+:4], rdata_r[ST_ADDR_LSB+:12], rdata_r[ST_MATCH_BIT]}, {4'h3, 12'd5, 1'b1})
    // masked compare hits, unmasked one misses and loads the comparand
    apb(1'b1, OFF_MASK1, 32'hFF00_0000);
    hw(1'b0, 1'b1, {CAT_CMP, 8'h01}, {8'hAB, PAT[23:0]}, 1'b0);
    `CHK({cam_match_flag_n, active_addr_out}, {1'b0, 12'd5})
    hw(1'b0, 1'b1, {CAT_CMP, 8'h10}, {8'hAB, PAT[23:0]}, 1'b0);
    `CHK(cam_match_flag_n, 1'b1)
    apb(1'b0, OFF_CMP, '0);
    `CHK(rdata_r, {8'hAB, PAT[23:0]})
    hw(1'b1, 1'b1, {CAT_REG, 8'h00}, '0, 1'b1);
    `CHK(rd, {8'hAB, PAT[23:0]})
    hw(1'b0, 1'b1, {CAT_CMP, 8'h09}, 32'h0000_0000, 1'b0);
    `CHK({cam_match_flag_n, active_addr_out}, {1'b0, 12'd5})
    // a higher device's match drives our flag on a local miss
    i_host.cascade_match_in_n <= 1'b0;
    hw(1'b0, 1'b1, {CAT_CMP, 8'h00}, 32'h0000_0000, 1'b0);
    `CHK(cam_match_flag_n, 1'b0)
    i_host.cascade_match_in_n <= 1'b1;
    // indirect writes stepping up, then reads stepping down
    hw(1'b0, 1'b1, {CAT_ADDR, 8'h00}, 32'd10, 1'b0);
    hw(1'b0, 1'b1, {CAT_MEM, 8'h01}, 32'h0000_00A1, 1'b0);
    hw(1'b0, 1'b1, {CAT_MEM, 8'h01}, 32'h0000_00B2, 1'b0);
    apb(1'b0, OFF_ADDR, '0);
    `CHK(rdata_r[AW-1:0], 12'd12)
    hw(1'b0, 1'b1, {CAT_ADDR, 8'h00}, 32'd11, 1'b0);
    hw(1'b1, 1'b1, {CAT_MEM, 8'h02}, '0, 1'b1);
    `CHK(rd, 32'h0000_00B2)
    hw(1'b1, 1'b1, {CAT_MEM, 8'h02}, '0, 1'b1);
    `CHK(rd, 32'h0000_00A1)
    // set validity at the address register: location 9 becomes empty
    hw(1'b0, 1'b1, {CAT_ADDR, 8'h00}, 32'd9, 1'b0);
    hw(1'b0, 1'b1, {CAT_MOVE, 8'h00}, '0, 1'b0);
    hw(1'b1, 1'b0, 12'd9, '0, 1'b1);
    `CHK({rvb, rd}, {1'b0, 8'hAB, PAT[23:0]})
    hw(1'b0, 1'b1, {CAT_VALID, 8'h00}, '0, 1'b1);
    hw(1'b1, 1'b0, 12'd9, '0, 1'b1);
    `CHK(rvb, 1'b1)
    // next free lands at 0; with the chain not full above, nothing lands
    hw(1'b0, 1'b1, {CAT_NFA, 8'h00}, 32'h0000_00C3, 1'b0);
    `CHK(active_addr_out, 12'd0)
    i_host.cascade_full_in_n <= 1'b1;
    hw(1'b0, 1'b1, {CAT_NFA, 8'h00}, 32'h0000_00D4, 1'b0);
    i_host.cascade_full_in_n <= 1'b0;
    hw(1'b1, 1'b0, 12'd1, '0, 1'b1);
    `CHK(rvb, 1'b1)
    // software mode: instruction writes only count while this device is selected
    apb(1'b1, OFF_CONFIG, 32'h0000_0031);
    apb(1'b1, OFF_ADDR, 32'd20);
    apb(1'b1, OFF_DATA, 32'h0000_00E5);
    apb(1'b1, OFF_INSTR, 32'h0000_1100);
    repeat (4) @(posedge pclk);
    apb(1'b1, OFF_DEVSEL, 32'h0000_0000);
    apb(1'b1, OFF_DATA, 32'h0000_00F6);
    apb(1'b1, OFF_INSTR, 32'h0000_1100);
    repeat (4) @(posedge pclk);
    hw(1'b0, 1'b0, 12'd20, 32'h0000_0077, 1'b0);
    apb(1'b1, OFF_DEVSEL, 32'h0000_0001);
    apb(1'b1, OFF_INSTR, 32'h0000_0100);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_DATA, '0);
    `CHK(rdata_r, 32'h0000_00E5)
    // software compare hits at 5, but a higher device match keeps our pointer
    i_host.cascade_match_in_n <= 1'b0;
    apb(1'b1, OFF_INSTR, 32'h0000_0309);
    @(posedge pclk);
    `CHK({cam_match_flag_n, active_addr_out}, {1'b0, 12'd20})
    i_host.cascade_match_in_n <= 1'b1;
    apb(1'b1, OFF_CONFIG, 32'h0000_0030);
    // init empties the array, then next-free fills it word by word
    hw(1'b0, 1'b1, {CAT_INIT, 8'h00}, '0, 1'b0);
    hw(1'b1, 1'b0, 12'd5, '0, 1'b1);
    `CHK(rvb, 1'b1)
    for (int i = 0; i < DEPTH; i++) begin
      if (i == DEPTH - 1) `CHK(array_full_flag_n, 1'b1)
      hw(1'b0, 1'b1, {CAT_NFA, 8'h00}, DW'(i), 1'b0);
    end
    `CHK(array_full_flag_n, 1'b0)
    hw(1'b1, 1'b0, 12'hFFF, '0, 1'b1);
    `CHK({rvb, rd}, {1'b0, 32'h0000_0FFF})
    end_of_test();
  end
endmodule : atm_header_lookup_cam_tb
